// ### src/sms_sequencer.sv
// Purpose: Excitation index, current targets, marker and enables of a two-channel stepper
// Assumes: Step clock and pins synchronous to clk; sense comparators outside
// Notes: Targets settle two clocks after a step edge; marker follows one clock later
//
// Function
// (RULE1) Two-phase: both channels full magnitude together, chopping PWM held off.
// (RULE2) Microstep: one electrical cycle is 64 equal sine steps.
// (RULE3) Microstep: each bridge is PWM-switched by current versus reference comparison.
// (RULE4) Two-phase: marker low when both channels are at full magnitude.
// (RULE5) Output enable low releases the marker to high impedance.
// (RULE6) Stop set: step until marker low, then ignore step edges and hold.
// (RULE7) Stop dropped before marker reached: stepping continues as in normal mode.
// (RULE8) Reset low initialises position and puts motor outputs in high impedance.
// (RULE9) Start at channel one full, channel two zero; two-phase both full positive.
// (RULE10) After reset the marker stays low until the first step is output.
// (RULE11) Output enable low forces motor outputs to high impedance.
// (RULE12) Standby when idle with power save and stop high; leave when both low.
// (RULE13) Power save and stop high: step to marker, then motor outputs off.
// (RULE14) Host never applies power save high with stop low.
// (RULE15) Each rising step clock edge advances the position by exactly one.
// (RULE16) Microstep current comes from position index and direction.
// (RULE17) Two-phase: channel polarities change on every step pulse.
// (RULE18) Direction low: channel two lags by 90 degrees; high: leads.
// (RULE19) Microstep to two-phase: hold, then jump to next quadrant's two-phase point.
// (RULE20) Microstep marker: pattern low one point per cycle, high every full point.
// (RULE21) Stop and power save act only in microstep mode.
// (RULE22) Host pulses reset low after every power-up.
// (RULE23) Position is a modulo-64 up/down counter by direction.
module sms_sequencer (
  input wire logic clk, // System clock, 200 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic reset_n, // Device reset pin, active low
  input wire logic step_clock, // Step clock pin
  input wire sms_pkg::sms_ctrl_type ctrl, // Control pin group
  input wire logic sense_over_one, // Channel one current above reference
  input wire logic sense_over_two, // Channel two current above reference
  output sms_pkg::sms_bridge_type bridge_one, // Channel one bridge drive
  output sms_pkg::sms_bridge_type bridge_two, // Channel two bridge drive
  output logic position_marker_out, // Marker pin output value (always low)
  output logic position_marker_oe, // Marker pin output enable
  output logic standby, // Standby indication
  output logic [5:0] position // Excitation index
);
  sms_pkg::sms_state_type state, next_state;
  logic [5:0] next_position;
  logic step_prev, next_step_prev;
  logic stepped, next_stepped;
  logic two_phase_latched, next_two_phase_latched;
  logic [6:0] pwm_cnt, next_pwm_cnt;
  logic marker_hit, next_marker_hit;
  logic [6:0] mag_one, mag_two;
  logic neg_one, neg_two, next_neg_one, next_neg_two;
  logic [4:0] addr_one, addr_two;
  logic [5:0] pos_two;
  logic step_edge, step_taken, full_one, full_two, at_stop;
  logic signed [7:0] next_target_one, next_target_two;
  logic signed [7:0] target_one, target_two;

  // Quarter-wave folding: index into 0..16 and sign of the half cycle
  function automatic logic [4:0] fold_addr(input logic [5:0] p);
    logic [4:0] q;
    q = {1'b0, p[3:0]};
    if (p[4]) begin
      q = 5'(sms_pkg::QUARTER_STEPS) - {1'b0, p[3:0]};
    end
    return q;
  endfunction : fold_addr

  function automatic logic signed [7:0] signed_of(input logic [6:0] m, input logic neg);
    logic signed [7:0] s;
    s = $signed({1'b0, m});
    if (neg) begin
      s = -s;
    end
    return s;
  endfunction : signed_of

  // Channel one follows cos of the index, channel two sin; direction acts only through
  // the count direction, since a second sign flip would make channel two lag both ways
  always_comb begin
    pos_two = position; // [RULE18]
    addr_one = fold_addr(position + sms_pkg::PHASE_OFFSET); // [RULE2]
    addr_two = fold_addr(pos_two);
    next_neg_one = (position + sms_pkg::PHASE_OFFSET) >= 6'h20;
    next_neg_two = pos_two >= 6'h20; // [RULE16] [RULE18]
    if (position[4:0] == 5'h00) begin
      next_neg_two = 1'b0;
    end
  end

  sms_sine_rom u_rom (
    .clk(clk),
    .sys_rst(sys_rst),
    .addr_a(addr_one),
    .addr_b(addr_two),
    .data_a(mag_one),
    .data_b(mag_two)
  );

  always_comb begin
    step_edge = step_clock && !step_prev; // [RULE15]
    full_one = (target_one == $signed({1'b0, sms_pkg::FULL_SCALE}))
      || (target_one == -$signed({1'b0, sms_pkg::FULL_SCALE}));
    full_two = (target_two == $signed({1'b0, sms_pkg::FULL_SCALE}))
      || (target_two == -$signed({1'b0, sms_pkg::FULL_SCALE}));
    at_stop = ctrl.microstep_mode && ctrl.stop_select && marker_hit && stepped; // [RULE6] [RULE21]
    next_state = state;
    unique case (state)
      sms_pkg::SMS_RUN: begin
        if (at_stop) begin
          next_state = ctrl.power_save_select
            ? sms_pkg::SMS_STANDBY : sms_pkg::SMS_HOLD; // [RULE13]
        end
      end
      sms_pkg::SMS_HOLD: begin
        // Hold lasts only while the marker stands; a new pattern restarts stepping
        if (!ctrl.stop_select || !ctrl.microstep_mode || !marker_hit) begin // [RULE6] [RULE7]
          next_state = sms_pkg::SMS_RUN;
        end else if (ctrl.power_save_select) begin
          next_state = sms_pkg::SMS_STANDBY; // [RULE12]
        end
      end
      sms_pkg::SMS_STANDBY: begin
        if (!ctrl.power_save_select && !ctrl.stop_select) begin // [RULE12]
          next_state = sms_pkg::SMS_RUN;
        end
      end
      default: next_state = sms_pkg::SMS_RUN;
    endcase
    step_taken = step_edge && (state == sms_pkg::SMS_RUN) && !at_stop; // [RULE6]
    next_step_prev = step_clock;
    next_position = position;
    next_two_phase_latched = two_phase_latched;
    next_stepped = stepped;
    if (step_taken) begin
      next_stepped = 1'b1;
      if (ctrl.microstep_mode) begin
        next_two_phase_latched = 1'b0;
        next_position = ctrl.direction_select ? position - 6'h01 : position + 6'h01; // [RULE23]
      end else if (!two_phase_latched) begin
        // First two-phase step lands on a 45 degree point: forward the next one ahead, reverse the previous quadrant's
        next_two_phase_latched = 1'b1;
        next_position = ctrl.direction_select
          ? {position[5:4] - 2'h1, 4'h8} : {position[5:4] + (position[3] ? 2'h1 : 2'h0), 4'h8};
        if (!stepped) begin
          next_position = ctrl.direction_select ? 6'h38 : 6'h18; // [RULE19]
        end
      end else begin
        next_position = ctrl.direction_select ? position - 6'h10 : position + 6'h10; // [RULE17]
      end
    end
    // Before any step after reset two-phase shows both channels positive; after a
    // switch from microstep the old targets stand until the first two-phase step
    next_target_one = signed_of(mag_one, neg_one);
    next_target_two = signed_of(mag_two, neg_two);
    if (!ctrl.microstep_mode) begin
      if (two_phase_latched) begin
        next_target_one = signed_of(sms_pkg::FULL_SCALE, neg_one); // [RULE1]
        next_target_two = signed_of(sms_pkg::FULL_SCALE, neg_two);
      end else if (!stepped) begin
        next_target_one = $signed({1'b0, sms_pkg::FULL_SCALE}); // [RULE9]
        next_target_two = $signed({1'b0, sms_pkg::FULL_SCALE});
      end else begin
        next_target_one = target_one; // [RULE19]
        next_target_two = target_two;
      end
    end
    if (!ctrl.microstep_mode) begin
      next_marker_hit = full_one && full_two; // [RULE4]
    end else if (ctrl.marker_pattern_select) begin
      next_marker_hit = full_one || full_two; // [RULE20]
    end else begin
      next_marker_hit = (target_one == $signed({1'b0, sms_pkg::FULL_SCALE}))
        && (target_two == 8'sh00); // [RULE20]
    end
    if (!stepped) begin
      next_marker_hit = 1'b1; // [RULE10]
    end
    next_pwm_cnt = (pwm_cnt == 7'(sms_pkg::FULL_SCALE - 7'h01)) ? 7'h00 : pwm_cnt + 7'h01;
    if (state == sms_pkg::SMS_STANDBY) begin
      next_pwm_cnt = pwm_cnt; // [RULE12]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= sms_pkg::SMS_RUN;
      position <= sms_pkg::RESET_POS;
      step_prev <= 1'b0;
      stepped <= 1'b0;
      two_phase_latched <= 1'b0;
      marker_hit <= 1'b1;
      pwm_cnt <= 7'h00;
      neg_one <= 1'b0;
      neg_two <= 1'b0;
      target_one <= 8'sh00;
      target_two <= 8'sh00;
    end else if (!reset_n) begin
      state <= sms_pkg::SMS_RUN; // [RULE8]
      position <= sms_pkg::RESET_POS;
      step_prev <= step_clock;
      stepped <= 1'b0;
      two_phase_latched <= 1'b0;
      marker_hit <= 1'b1;
      pwm_cnt <= 7'h00;
      neg_one <= 1'b0;
      neg_two <= 1'b0;
      target_one <= 8'sh00;
      target_two <= 8'sh00;
    end else begin
      state <= next_state;
      position <= next_position;
      step_prev <= next_step_prev;
      stepped <= next_stepped;
      two_phase_latched <= next_two_phase_latched;
      marker_hit <= next_marker_hit;
      pwm_cnt <= next_pwm_cnt;
      neg_one <= next_neg_one;
      neg_two <= next_neg_two;
      target_one <= next_target_one;
      target_two <= next_target_two;
    end
  end

  // Chopping: drive while current is below reference, freewheel in the off part
  always_comb begin
    logic en;
    logic chop_one, chop_two;
    en = reset_n && ctrl.output_enable // [RULE8] [RULE11]
      && (state != sms_pkg::SMS_STANDBY); // [RULE13]
    chop_one = !sense_over_one && (pwm_cnt < (target_one[7] ? 7'(-target_one) : target_one[6:0]));
    chop_two = !sense_over_two && (pwm_cnt < (target_two[7] ? 7'(-target_two) : target_two[6:0]));
    if (!ctrl.microstep_mode) begin
      chop_one = 1'b1; // [RULE1]
      chop_two = 1'b1;
    end
    bridge_one.target = target_one;
    bridge_two.target = target_two;
    bridge_one.drive_en = en;
    bridge_two.drive_en = en;
    bridge_one.drive_a = en && chop_one && !target_one[7] && (target_one != 8'sh00); // [RULE3]
    bridge_one.drive_b = en && chop_one && target_one[7];
    bridge_two.drive_a = en && chop_two && !target_two[7] && (target_two != 8'sh00); // [RULE3]
    bridge_two.drive_b = en && chop_two && target_two[7];
    position_marker_out = 1'b0;
    position_marker_oe = ctrl.output_enable && marker_hit; // [RULE5]
    standby = (state == sms_pkg::SMS_STANDBY);
  end
endmodule : sms_sequencer

// ### src/sms_pkg.sv
// Purpose: Shared constants and carrier types of the stepper microstep sequencer
// Assumes: One 200 MHz clock; all control pins synchronous to it
// Notes: Currents are signed percent-scaled codes, full scale is sms_pkg::FULL_SCALE
package sms_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned POS_WIDTH = 6;
  localparam int unsigned STEPS_PER_CYCLE = 64;
  localparam int unsigned QUARTER_STEPS = 16;
  localparam int unsigned CUR_WIDTH = 8;
  localparam int unsigned SINE_WIDTH = 7;
  localparam int unsigned PWM_WIDTH = 7;
  localparam logic [6:0] FULL_SCALE = 7'h64;
  localparam logic [5:0] RESET_POS = 6'h00;
  localparam logic [5:0] PHASE_OFFSET = 6'h10;
  localparam logic [5:0] TWO_PHASE_OFFSET = 6'h08;
  localparam logic [4:0] SINE_DEPTH = 5'h11;

  typedef enum logic [1:0] {
    SMS_RUN = 2'b00,
    SMS_HOLD = 2'b01,
    SMS_STANDBY = 2'b10
  } sms_state_type;

  // Pin group from the host controller
  typedef struct packed {
    logic direction_select;
    logic microstep_mode;
    logic stop_select;
    logic power_save_select;
    logic output_enable;
    logic marker_pattern_select;
  } sms_ctrl_type;

  // Per-channel drive towards an H-bridge
  typedef struct packed {
    logic signed [7:0] target;
    logic drive_a;
    logic drive_b;
    logic drive_en;
  } sms_bridge_type;
endpackage : sms_pkg

// ### src/sms_sine_rom.sv
// Purpose: Registered quarter-wave sine lookup, percent of full scale
// Assumes: Address 0..16 covers 0 to 90 degrees
// Notes: Read data appear one clock after the address
module sms_sine_rom (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [4:0] addr_a, // First read address
  input wire logic [4:0] addr_b, // Second read address
  output logic [6:0] data_a, // First read data
  output logic [6:0] data_b // Second read data
);
  function automatic logic [6:0] sine_of(input logic [4:0] a);
    logic [6:0] v;
    v = 7'h00;
    unique case (a)
      5'h00: v = 7'h00;
      5'h01: v = 7'h0a;
      5'h02: v = 7'h14;
      5'h03: v = 7'h1d;
      5'h04: v = 7'h26;
      5'h05: v = 7'h2f;
      5'h06: v = 7'h38;
      5'h07: v = 7'h3f;
      5'h08: v = 7'h47;
      5'h09: v = 7'h4d;
      5'h0a: v = 7'h53;
      5'h0b: v = 7'h58;
      5'h0c: v = 7'h5c;
      5'h0d: v = 7'h60;
      5'h0e: v = 7'h62;
      5'h0f: v = 7'h64;
      5'h10: v = 7'h64;
      default: v = 7'h00;
    endcase
    return v;
  endfunction : sine_of

  logic [6:0] next_data_a;
  logic [6:0] next_data_b;

  always_comb begin
    next_data_a = sine_of(addr_a);
    next_data_b = sine_of(addr_b);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_a <= 7'h00;
      data_b <= 7'h00;
    end else begin
      data_a <= next_data_a;
      data_b <= next_data_b;
    end
  end
endmodule : sms_sine_rom

// ### verification/sms_coil_model.sv
// Purpose: Coil current model behind one bridge, feeding the sense comparator
// Assumes: One count of current per clock while a bridge leg drives
// Notes: Released bridge drops the current at once, harsher than a real coil
module sms_coil_model (
  input wire logic clk, // System clock
  input wire sms_pkg::sms_bridge_type bridge, // Bridge drive
  output logic sense_over // Current above reference
);
  timeunit 1ns;
  timeprecision 100ps;
  logic signed [8:0] cur = 9'h000;
  logic signed [8:0] tgt;
  always @(posedge clk) begin
    if (!bridge.drive_en) begin
      cur <= 9'h000;
    end else if (bridge.drive_a) begin
      cur <= cur + 9'h001;
    end else if (bridge.drive_b) begin
      cur <= cur - 9'h001;
    end
  end
  assign tgt = {bridge.target[7], bridge.target};
  // Magnitude compare, so both polarities chop alike
  assign sense_over = (cur[8] ? -cur : cur) > (tgt[8] ? -tgt : tgt);
endmodule : sms_coil_model

// ### verification/sms_sequencer_monitor.sv
// Purpose: Port assertions of the sequencer
// Assumes: Bound into every sms_sequencer
// Notes: Marker timing assumes steps at least four clocks apart
module sms_sequencer_monitor (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic reset_n, // Device reset
  input wire logic step_clock, // Step pin
  input wire sms_pkg::sms_ctrl_type ctrl, // Pins
  input wire sms_pkg::sms_bridge_type bridge_one, // Channel one
  input wire sms_pkg::sms_bridge_type bridge_two, // Channel two
  input wire logic position_marker_oe, // Marker
  input wire logic standby, // Standby
  input wire logic [5:0] position // Index
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic full;
  logic run;
  assign full = (bridge_one.target == 8'h64 || bridge_one.target == 8'h9c)
    && (bridge_two.target == 8'h64 || bridge_two.target == 8'h9c);
  logic [5:0] prev_pos;
  logic prev_rn;
  // Previous index and reset pin, so that a move can be spotted outside properties
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_pos <= 6'h00;
      prev_rn <= 1'b0;
    end else begin
      prev_pos <= position;
      prev_rn <= reset_n;
    end
  end
  assign run = reset_n && prev_rn && position != prev_pos;
  property p_oe_br;
    !ctrl.output_enable |-> !bridge_one.drive_en && !bridge_two.drive_en;
  endproperty
  a_oe_br: assert property (p_oe_br) else $error("bridge on, enable low");
  property p_oe_mk;
    !ctrl.output_enable |-> !position_marker_oe;
  endproperty
  a_oe_mk: assert property (p_oe_mk) else $error("marker on, enable low");
  property p_rst;
    !reset_n |-> !bridge_one.drive_en && !bridge_two.drive_en ##1 position == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not applied");
  property p_rst_mk;
    !reset_n && ctrl.output_enable ##1 ctrl.output_enable |-> position_marker_oe;
  endproperty
  a_rst_mk: assert property (p_rst_mk) else $error("marker off in reset");
  property p_edge;
    run |-> $past(step_clock) && !$past(step_clock, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("move without step edge");
  property p_mod;
    run && ctrl.microstep_mode && $past(ctrl.microstep_mode)
      |-> position - $past(position) inside {6'h01, 6'h3f};
  endproperty
  a_mod: assert property (p_mod) else $error("index moved by more than one");
  property p_sby;
    standby |-> !bridge_one.drive_en && !bridge_two.drive_en;
  endproperty
  a_sby: assert property (p_sby) else $error("bridge on in standby");
  property p_two;
    run && !ctrl.microstep_mode && ctrl.output_enable |-> ##3 full && position_marker_oe;
  endproperty
  a_two: assert property (p_two) else $error("two-phase not full");
endmodule : sms_sequencer_monitor
bind sms_sequencer sms_sequencer_monitor u_mon (.clk, .sys_rst, .reset_n, .step_clock,
  .ctrl, .bridge_one, .bridge_two, .position_marker_oe, .standby, .position);

// ### verification/sms_sequencer_bench.sv
// Purpose: Directed bench of the sequencer
// Assumes: Pins change 1 ns after the rising edge
// Notes: Steps six clocks apart so targets and marker settle
module sms_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_n = 1'b0;
  logic step_clock = 1'b0;
  sms_pkg::sms_ctrl_type ctrl = 6'h12;
  logic so_one, so_two, mk_oe, mk_out, standby;
  sms_pkg::sms_bridge_type b_one, b_two;
  logic [5:0] position;
  logic [15:0] prev;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  logic [6:0] sine [0:16] = '{7'h00, 7'h0a, 7'h14, 7'h1d, 7'h26, 7'h2f, 7'h38, 7'h3f,
    7'h47, 7'h4d, 7'h53, 7'h58, 7'h5c, 7'h60, 7'h62, 7'h64, 7'h64};
  always #2.5 clk = ~clk;
  sms_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .reset_n(reset_n),
    .step_clock(step_clock), .ctrl(ctrl), .sense_over_one(so_one),
    .sense_over_two(so_two), .bridge_one(b_one), .bridge_two(b_two),
    .position_marker_out(mk_out), .position_marker_oe(mk_oe), .standby(standby),
    .position(position));
  sms_coil_model u_one (.clk(clk), .bridge(b_one), .sense_over(so_one));
  sms_coil_model u_two (.clk(clk), .bridge(b_two), .sense_over(so_two));
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic step;
    step_clock = 1'b1;
    tick(1);
    step_clock = 1'b0;
    tick(5);
  endtask : step
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic full(input logic [7:0] t);
    return t === 8'h64 || t === 8'h9c;
  endfunction : full
  task automatic results;
    $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic dev_reset;
    reset_n = 1'b0;
    tick(3);
    chk("pos_rst", 8'h00, 8'(position));
    chk("en_rst", 8'h00, 8'(b_one.drive_en | b_two.drive_en));
    reset_n = 1'b1;
    tick(5);
    chk("t1_start", 8'h64, b_one.target);
    chk("mk_start", 8'h01, 8'(mk_oe));
    chk("mk_pin", 8'h00, 8'(mk_out));
  endtask : dev_reset
  initial begin
    tick(16);
    sys_rst = 1'b0;
    tick(2);
    dev_reset;
    chk("t2_start", 8'h00, b_two.target);
    $display("Test reset done");
    for (int i = 1; i <= 16; i++) begin
      step;
      chk("pos_fwd", 8'(i), 8'(position));
      chk("t1_fwd", {1'b0, sine[16-i]}, b_one.target);
      chk("t2_fwd", {1'b0, sine[i]}, b_two.target);
      chk("mk_one", 8'h00, 8'(mk_oe));
    end
    ctrl.marker_pattern_select = 1'b1;
    ctrl.stop_select = 1'b1;
    tick(4);
    chk("mk_four", 8'h01, 8'(mk_oe));
    step;
    chk("pos_hold", 8'h10, 8'(position));
    $display("Test forward done");
    ctrl.marker_pattern_select = 1'b0;
    ctrl.direction_select = 1'b1;
    tick(4);
    n = 0;
    while (mk_oe !== 1'b1 && n < 64) begin
      step;
      n++;
    end
    if (n == 64) begin
      bad_count++;
      $display("ERROR marker_wait expected 1 seen 0");
      results;
    end
    chk("stop_steps", 8'h10, 8'(n));
    step;
    chk("pos_stop", 8'h00, 8'(position));
    ctrl.stop_select = 1'b0;
    tick(1);
    step;
    chk("pos_rev", 8'h3f, 8'(position));
    chk("t1_rev", 8'h64, b_one.target);
    $display("Test stop done");
    ctrl.direction_select = 1'b0;
    ctrl.stop_select = 1'b1;
    tick(1);
    ctrl.power_save_select = 1'b1;
    step;
    tick(3);
    chk("pos_ps", 8'h00, 8'(position));
    chk("sby_on", 8'h01, 8'(standby));
    step;
    chk("pos_sby", 8'h00, 8'(position));
    ctrl.power_save_select = 1'b0;
    tick(1);
    ctrl.stop_select = 1'b0;
    tick(3);
    chk("sby_off", 8'h00, 8'(standby));
    ctrl.output_enable = 1'b0;
    tick(2);
    chk("en_off", 8'h00, {6'h00, b_one.drive_en, b_two.drive_en});
    chk("mk_off", 8'h00, 8'(mk_oe));
    ctrl.output_enable = 1'b1;
    tick(2);
    chk("en_on", 8'h03, {6'h00, b_one.drive_en, b_two.drive_en});
    step;
    chk("pos_wake", 8'h01, 8'(position));
    // Channel two target is small here, so the bridge must spend part of each period off
    n = 0;
    repeat (100) begin
      tick(1);
      n += b_two.drive_a;
    end
    chk("chop", 8'h01, 8'(n > 0 && n < 100));
    $display("Test power save done");
    ctrl.microstep_mode = 1'b0;
    tick(4);
    chk("t2_keep", 8'h0a, b_two.target);
    for (int i = 0; i < 5; i++) begin
      prev = {b_one.target, b_two.target};
      step;
      chk("full_one", 8'h01, 8'(full(b_one.target)));
      chk("full_two", 8'h01, 8'(full(b_two.target)));
      chk("mk_two", 8'h01, 8'(mk_oe));
      chk("no_chop", 8'h01, 8'(b_one.drive_a ^ b_one.drive_b));
      chk("flip", 8'h01, 8'(prev !== {b_one.target, b_two.target}));
    end
    chk("pos_quad", 8'h08, {4'h0, position[3:0]});
    dev_reset;
    chk("t2_two", 8'h64, b_two.target);
    $display("Test two-phase done");
    results;
  end
endmodule : sms_sequencer_bench
